/* verilog/pocc_pkg.sv */
// pocc_pkg: register layout, field positions, reset values and codes of the
// output and pll configuration block.
// assumes 32-bit serial words whose low 4 bits carry the register address.
package pocc_pkg;

    // ==========================================================
    // register addresses (low nibble of each serial word)
    localparam logic [3:0] POCC_ADDR_OUT_FIRST = 4'h0;
    localparam logic [3:0] POCC_ADDR_OUT_LAST  = 4'h7;
    localparam logic [3:0] POCC_ADDR_LOCK_DET  = 4'hb;
    localparam logic [3:0] POCC_ADDR_REF_CTL   = 4'he;
    localparam logic [3:0] POCC_ADDR_FB_CTL    = 4'hf;

    // ==========================================================
    // field positions
    localparam int POCC_ADDR_LSB      = 0;
    localparam int POCC_OUT_EN_BIT    = 16;
    localparam int POCC_PRESCALE_BIT  = 15;
    localparam int POCC_GLOBAL_EN_BIT = 27;
    localparam int POCC_SLEEP_BIT     = 26;
    localparam int POCC_FLOAT_BIT     = 25;
    localparam int POCC_POL_BIT       = 24;
    localparam int POCC_MUX_LSB       = 20;
    localparam int POCC_REF_LSB       = 8;
    localparam int POCC_GAIN_LSB      = 30;
    localparam int POCC_FB_LSB        = 8;

    // ==========================================================
    // widths and reset values
    localparam int POCC_NUM_OUT = 8;
    localparam int POCC_REF_W   = 12;
    localparam int POCC_FB_W    = 18;
    localparam logic [POCC_REF_W-1:0] POCC_REF_RST = 12'h00a;
    localparam logic [POCC_FB_W-1:0]  POCC_FB_RST  = 18'h002f8;
    localparam logic [1:0]            POCC_PRESCALE_DIV = 2'h3;

    // ==========================================================
    // lock/test pin source codes
    typedef enum logic [3:0] {
        POCC_PIN_HIZ    = 4'h0,
        POCC_PIN_HIGH   = 4'h1,
        POCC_PIN_LOW    = 4'h2,
        POCC_PIN_LD_HI  = 4'h3,
        POCC_PIN_LD_LO  = 4'h4,
        POCC_PIN_FB_DIV = 4'h9,
        POCC_PIN_REF_DIV= 4'hb
    } pocc_pin_e;

    // charge pump gain codes: 1x, 4x, 16x, 32x
    typedef enum logic [1:0] {
        POCC_GAIN_1X  = 2'h0,
        POCC_GAIN_4X  = 2'h1,
        POCC_GAIN_16X = 2'h2,
        POCC_GAIN_32X = 2'h3
    } pocc_gain_e;

    // configuration held in the reference clock domain
    typedef struct packed {
        logic [POCC_NUM_OUT-1:0] out_en;
        logic                    prescale;
        logic                    global_en;
        logic                    sleep;
        logic                    pump_float;
        logic                    pump_pol;
        logic [3:0]              pin_sel;
        logic [POCC_REF_W-1:0]   ref_div;
        logic [POCC_FB_W-1:0]    fb_div;
        logic [1:0]              pump_gain;
    } pocc_cfg_s;

    localparam pocc_cfg_s POCC_CFG_RST = '{
        out_en: '0, prescale: 1'b0, global_en: 1'b1, sleep: 1'b0,
        pump_float: 1'b0, pump_pol: 1'b0, pin_sel: 4'h0,
        ref_div: POCC_REF_RST, fb_div: POCC_FB_RST, pump_gain: 2'h0};

endpackage : pocc_pkg

/* verilog/pocc_div.sv */
// pocc_div: programmable binary divider with a half-rate 50% duty output.
// assumes its terminal count is stable or changes only between pulses.
`timescale 1ns/1ps
`default_nettype none
module pocc_div
    import pocc_pkg::*;
#(
    parameter int W = 12
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // control
    input  wire logic [W-1:0] div_val,
    input  wire logic         run,
    // outputs
    output logic              pulse,
    output logic              half
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         pulse;
        logic         half;
    } pocc_div_s;

    pocc_div_s st_q;
    pocc_div_s st_d;

    always_comb begin
        st_d       = st_q;
        st_d.pulse = 1'b0;
        // zero count or stopped: hold still rather than toggle randomly
        if (!run || div_val == '0) begin
            st_d.cnt = '0;
        end else if (st_q.cnt >= div_val - W'(1)) begin
            // reload compares against the live value with >=, so a new count governs
            // the period in progress, and a count already past it wraps at once
            st_d.cnt   = '0;
            st_d.pulse = 1'b1;
            st_d.half  = ~st_q.half;
        end else begin
            st_d.cnt = st_q.cnt + W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pulse = st_q.pulse;
    assign half  = st_q.half;
endmodule : pocc_div
`default_nettype wire

/* verilog/pocc_serial_rx.sv */
// pocc_serial_rx: three-wire shift register on the serial clock.
// assumes the host shifts msb first and raises latch after 32 bits.
`timescale 1ns/1ps
`default_nettype none
module pocc_serial_rx
    import pocc_pkg::*;
(
    // serial link
    input  wire logic        ser_clk,
    input  wire logic        rst_n,
    input  wire logic        ser_data,
    // shifted word, held while latch is high
    output logic [31:0]      word
);
    typedef struct packed {
        logic [31:0] sh;
    } pocc_rx_s;

    pocc_rx_s st_q;
    pocc_rx_s st_d;

    always_comb begin
        st_d    = st_q;
        st_d.sh = {st_q.sh[30:0], ser_data};
    end

    // the serial clock stops outside frames, so the word simply rests here
    always_ff @(posedge ser_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign word = st_q.sh;
endmodule : pocc_serial_rx
`default_nettype wire

/* verilog/pocc_top.sv */
// pocc_top: output gating, divider and status-pin configuration of a clock
// conditioner, written over a three-wire latched serial link.
// assumes clk is the reference clock; ser_clk is the host's serial clock.
//
// What this block does
// - output drives only if own bit, global bit and global pin all high
// - each output has its own enable bit, reset to disabled
// - prescale bit divides lock detect input by four, reset undivided
// - reference divider is plain 12-bit binary, zero invalid, reset ten
// - status pin: hiz, high, low, feedback/2, reference/2 by select code
// - codes three and four drive lock detect active high or low
// - sleep bit stops both dividers, clock outputs, status pin and lock detect enable, and floats the pump
// - global enable bit low turns all outputs off, reset high
// - float bit places the charge pump output in high impedance
// - polarity bit: zero negative, one positive, reset negative
// - feedback divider is 18-bit binary counter, zero invalid, reset 760
// - feedback divider feeds phase detector: fvco = fref * n / r
// - gain field picks 1x, 4x, 16x or 32x, reset 1x
`timescale 1ns/1ps
`default_nettype none
module pocc_top
    import pocc_pkg::*;
#(
    parameter int NUM_OUT = POCC_NUM_OUT
) (
    // reference clock domain
    input  wire logic               clk,
    input  wire logic               rst_n,
    // serial link (own clock domain)
    input  wire logic               ser_clk,
    input  wire logic               ser_data,
    input  wire logic               ser_latch,
    // pins
    input  wire logic               all_outputs_enable_pin,
    input  wire logic               lock_detect_in,
    output logic                    lock_test_pin_o,
    output logic                    lock_test_pin_oe,
    // clock output gating
    output logic [NUM_OUT-1:0]      clk_out_enable,
    // pll analog controls
    output logic                    pump_float_bit,
    output logic                    pump_polarity_bit,
    output pocc_gain_e              pump_gain_field,
    output logic                    device_sleep_bit,
    output logic                    lock_detect_prescale,
    output logic                    fb_div_pulse,
    output logic                    ref_div_pulse,
    output logic                    lock_detect_clk_en
);
    // ==========================================================
    // serial receive on the link clock
    logic [31:0] rx_word;

    pocc_serial_rx u_rx (
        .ser_clk  (ser_clk),
        .rst_n    (rst_n),
        .ser_data (ser_data),
        .word     (rx_word)
    );

    // ==========================================================
    // state of this module
    typedef struct packed {
        logic [1:0]         latch_sync;
        logic               latch_prev;
        logic [1:0]         goe_sync;
        logic [1:0]         ld_sync;
        logic [1:0]         pre_cnt;
        logic               pre_en;
        pocc_cfg_s          cfg;
        logic               pin_o;
        logic               pin_oe;
        logic [NUM_OUT-1:0] out_en;
    } pocc_top_s;

    pocc_top_s st_q;
    pocc_top_s st_d;

    logic fb_half;
    logic ref_half;
    logic fb_pulse;
    logic ref_pulse;

    // ==========================================================
    // dividers
    pocc_div #(.W(POCC_REF_W)) u_ref_div (
        .clk     (clk),
        .rst_n   (rst_n),
        .div_val (st_q.cfg.ref_div),
        .run     (~st_q.cfg.sleep),
        .pulse   (ref_pulse),
        .half    (ref_half)
    );

    // n divider output goes to the phase detector alongside r's output
    pocc_div #(.W(POCC_FB_W)) u_fb_div (
        .clk     (clk),
        .rst_n   (rst_n),
        .div_val (st_q.cfg.fb_div),
        .run     (~st_q.cfg.sleep),
        .pulse   (fb_pulse),
        .half    (fb_half)
    );

    // ==========================================================
    // next state
    logic [3:0] addr;
    logic       strobe;
    logic       ld_now;

    always_comb begin
        st_d   = st_q;
        addr   = rx_word[POCC_ADDR_LSB +: 4];
        // rx_word is quiet while latch is high: the link clock has stopped
        strobe = st_q.latch_sync[1] & ~st_q.latch_prev;
        ld_now = st_q.ld_sync[1];

        st_d.latch_sync = {st_q.latch_sync[0], ser_latch};
        st_d.latch_prev = st_q.latch_sync[1];
        st_d.goe_sync   = {st_q.goe_sync[0], all_outputs_enable_pin};
        st_d.ld_sync    = {st_q.ld_sync[0], lock_detect_in};

        // fields change only on a completed write
        if (strobe) begin
            if (addr <= POCC_ADDR_OUT_LAST) begin
                st_d.cfg.out_en[addr[2:0]] = rx_word[POCC_OUT_EN_BIT];
            end else if (addr == POCC_ADDR_LOCK_DET) begin
                st_d.cfg.prescale = rx_word[POCC_PRESCALE_BIT];
            end else if (addr == POCC_ADDR_REF_CTL) begin
                st_d.cfg.global_en  = rx_word[POCC_GLOBAL_EN_BIT];
                st_d.cfg.sleep      = rx_word[POCC_SLEEP_BIT];
                st_d.cfg.pump_float = rx_word[POCC_FLOAT_BIT];
                st_d.cfg.pump_pol   = rx_word[POCC_POL_BIT];
                st_d.cfg.pin_sel    = rx_word[POCC_MUX_LSB +: 4];
                st_d.cfg.ref_div    = rx_word[POCC_REF_LSB +: POCC_REF_W];
            end else if (addr == POCC_ADDR_FB_CTL) begin
                st_d.cfg.pump_gain = rx_word[POCC_GAIN_LSB +: 2];
                st_d.cfg.fb_div    = rx_word[POCC_FB_LSB +: POCC_FB_W];
            end
        end

        // lock detect sample enable, one in four when prescaled
        if (st_q.cfg.prescale) begin
            st_d.pre_cnt = st_q.pre_cnt + 2'h1;
            st_d.pre_en  = (st_q.pre_cnt == POCC_PRESCALE_DIV);
        end else begin
            st_d.pre_cnt = 2'h0;
            st_d.pre_en  = 1'b1;
        end

        // clock output gating
        for (int i = 0; i < NUM_OUT; i++) begin
            st_d.out_en[i] = st_q.cfg.out_en[i] & st_q.cfg.global_en
                           & st_q.goe_sync[1] & ~st_q.cfg.sleep;
        end

        // status pin source; invalid codes leave the pin undriven
        st_d.pin_oe = 1'b1;
        st_d.pin_o  = 1'b0;
        case (st_q.cfg.pin_sel)
            POCC_PIN_HIGH:    st_d.pin_o  = 1'b1;
            POCC_PIN_LOW:     st_d.pin_o  = 1'b0;
            POCC_PIN_LD_HI:   st_d.pin_o  = ld_now;
            POCC_PIN_LD_LO:   st_d.pin_o  = ~ld_now;
            POCC_PIN_FB_DIV:  st_d.pin_o  = fb_half;
            POCC_PIN_REF_DIV: st_d.pin_o  = ref_half;
            default:          st_d.pin_oe = 1'b0;
        endcase
        if (st_q.cfg.sleep) begin
            st_d.pin_oe = 1'b0;
            st_d.pin_o  = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q            <= '0;
            st_q.cfg        <= POCC_CFG_RST;
            st_q.pre_en     <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // outputs
    assign clk_out_enable       = st_q.out_en;
    assign lock_test_pin_o      = st_q.pin_o;
    assign lock_test_pin_oe     = st_q.pin_oe;
    assign pump_float_bit       = st_q.cfg.pump_float | st_q.cfg.sleep;
    assign pump_polarity_bit    = st_q.cfg.pump_pol;
    assign pump_gain_field      = pocc_gain_e'(st_q.cfg.pump_gain);
    assign device_sleep_bit     = st_q.cfg.sleep;
    assign lock_detect_prescale = st_q.cfg.prescale;
    assign lock_detect_clk_en   = st_q.pre_en & ~st_q.cfg.sleep;
    assign fb_div_pulse         = fb_pulse;
    assign ref_div_pulse        = ref_pulse;
endmodule : pocc_top
`default_nettype wire

/* tb/pocc_chk.sv */
// pocc_chk: port-level assertions for pocc_top, reference clock domain only.
// assumes a bind into pocc_top; the serial latch is sampled as a plain input.
`timescale 1ns/1ps
`default_nettype none
module pocc_chk
    import pocc_pkg::*;
#(
    parameter int NUM_OUT = POCC_NUM_OUT
) (
    // clock and reset
    input wire logic               clk,
    input wire logic               rst_n,
    // watched ports
    input wire logic               ser_latch,
    input wire logic               all_outputs_enable_pin,
    input wire logic               lock_test_pin_oe,
    input wire logic [NUM_OUT-1:0] clk_out_enable,
    input wire logic               pump_float_bit,
    input wire logic               pump_polarity_bit,
    input wire pocc_gain_e         pump_gain_field,
    input wire logic               device_sleep_bit,
    input wire logic               lock_detect_prescale,
    input wire logic               fb_div_pulse,
    input wire logic               ref_div_pulse,
    input wire logic               lock_detect_clk_en
);
    // ==========================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    gate_pin_a: assert property (!all_outputs_enable_pin [*4] |-> clk_out_enable == '0)
        else $error("outputs enabled while enable pin low");
    reset_off_a: assert property ($rose(rst_n)
        |-> clk_out_enable == '0 && !lock_test_pin_oe)
        else $error("outputs or pin driven right after reset");
    sleep_float_a: assert property (device_sleep_bit && $past(device_sleep_bit)
        |-> pump_float_bit)
        else $error("charge pump not floating during sleep");
    sleep_quiet_a: assert property (device_sleep_bit [*3]
        |-> !lock_test_pin_oe && !fb_div_pulse && !ref_div_pulse)
        else $error("activity during sleep");
    ld_plain_a: assert property ((!lock_detect_prescale && !device_sleep_bit) [*2]
        |-> lock_detect_clk_en)
        else $error("lock detect gated without prescale");
    // a pulse under prescale must be followed by three quiet cycles
    ld_div_a: assert property (lock_detect_prescale && $past(lock_detect_prescale, 4)
        && lock_detect_clk_en |=> (!lock_detect_clk_en || !lock_detect_prescale) [*3])
        else $error("lock detect enable not divided by four");
    gain_latch_a: assert property ($changed(pump_gain_field) |-> $past(ser_latch, 2))
        else $error("gain changed without a latch");
    ctl_latch_a: assert property ($changed(pump_polarity_bit) || $changed(device_sleep_bit)
        || $changed(lock_detect_prescale) || $changed(pump_float_bit) |-> $past(ser_latch, 2))
        else $error("control bit changed without a latch");
endmodule : pocc_chk

bind pocc_top pocc_chk #(.NUM_OUT(NUM_OUT)) pocc_chk_inst (
    .clk(clk), .rst_n(rst_n), .ser_latch(ser_latch),
    .all_outputs_enable_pin(all_outputs_enable_pin), .lock_test_pin_oe(lock_test_pin_oe),
    .clk_out_enable(clk_out_enable), .pump_float_bit(pump_float_bit),
    .pump_polarity_bit(pump_polarity_bit), .pump_gain_field(pump_gain_field),
    .device_sleep_bit(device_sleep_bit), .lock_detect_prescale(lock_detect_prescale),
    .fb_div_pulse(fb_div_pulse), .ref_div_pulse(ref_div_pulse),
    .lock_detect_clk_en(lock_detect_clk_en));
`default_nettype wire

/* tb/pocc_host.sv */
// pocc_host: behavioural host on the three-wire latched serial link.
// assumes callers let write_word return before the next write.
`timescale 1ns/1ps
`default_nettype none
module pocc_host (
    // serial link
    output logic ser_clk,
    output logic ser_data,
    output logic ser_latch
);
    // ==========================================================
    // link clock stands still between frames
    initial begin
        ser_clk   = 1'b0;
        ser_data  = 1'b0;
        ser_latch = 1'b0;
    end

    // whole words only, fixed bits included
    task automatic write_word(input logic [31:0] w);
        // keep link edges off the reference clock grid
        #3;
        for (int i = 31; i >= 0; i--) begin
            ser_data = w[i];
            #80 ser_clk = 1'b1;
            #80 ser_clk = 1'b0;
        end
        // released data shows the inverse so a stale bit cannot pass
        ser_data = ~w[0];
        #37 ser_latch = 1'b1;
        #150 ser_latch = 1'b0;
        #60;
    endtask : write_word
endmodule : pocc_host
`default_nettype wire

/* tb/pocc_top_tb_top.sv */
// pocc_top_tb_top: self-checking bench for pocc_top driven through pocc_host.
// assumes a 100 MHz reference clock and the 160 ns host serial clock.
`timescale 1ns/1ps
`default_nettype none
module pocc_top_tb_top
    import pocc_pkg::*;
();
    logic       clk, rst_n, pin_en, ld_in, ser_clk, ser_data, ser_latch;
    logic       pin_o, pin_oe, float_b, pol_b, sleep_b, presc, fb_p, ref_p, ld_en;
    logic [7:0] outs;
    pocc_gain_e gain;
    int         mismatches, checks;
    // {code, drive enable, level} with lock detect high
    localparam logic [5:0] PIN_TAB [13] = '{6'h07, 6'h0a, 6'h0f, 6'h12, 6'h14, 6'h18, 6'h1c,
                                            6'h00, 6'h20, 6'h28, 6'h30, 6'h34, 6'h3c};

    pocc_host pocc_host_inst (.ser_clk(ser_clk), .ser_data(ser_data), .ser_latch(ser_latch));
    pocc_top pocc_top_inst (.clk(clk), .rst_n(rst_n), .ser_clk(ser_clk), .ser_data(ser_data),
        .ser_latch(ser_latch), .all_outputs_enable_pin(pin_en), .lock_detect_in(ld_in),
        .lock_test_pin_o(pin_o), .lock_test_pin_oe(pin_oe), .clk_out_enable(outs),
        .pump_float_bit(float_b), .pump_polarity_bit(pol_b), .pump_gain_field(gain),
        .device_sleep_bit(sleep_b), .lock_detect_prescale(presc), .fb_div_pulse(fb_p),
        .ref_div_pulse(ref_p), .lock_detect_clk_en(ld_en));

    // ==========================================================
    // helpers
    always #5 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    task automatic wr(input logic [31:0] w);
        pocc_host_inst.write_word(w);
        repeat (2) @(negedge clk);
    endtask : wr

    function automatic logic [31:0] r14(input logic g, s, f, p, input logic [3:0] m,
                                        input logic [11:0] r);
        return {4'h0, g, s, f, p, m, r, 8'h0e};
    endfunction : r14

    function automatic logic sel_sig(input int k);
        case (k)
            0: return ref_p;
            1: return fb_p;
            2: return pin_o;
            default: return ld_en;
        endcase
    endfunction : sel_sig

    // cycles up to the next rising edge of the chosen signal, bounded
    task automatic rise(input int k, output int n);
        logic p;
        n = 0;
        do begin
            p = sel_sig(k);
            @(negedge clk);
            n++;
        end while (!(sel_sig(k) && !p) && n < 9000);
    endtask : rise

    task automatic gap(input int k, input int exp);
        int n;
        rise(k, n);
        rise(k, n);
        check(n, exp);
    endtask : gap

    task automatic quiet(input int k);
        int n;
        n = 0;
        repeat (60) begin
            @(negedge clk);
            // an unknown counts as activity, so it cannot slip through
            if (sel_sig(k) !== 1'b0)
                n++;
        end
        check(n, 0);
    endtask : quiet

    // ==========================================================
    // tests
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        pin_en = 1'b1;
        ld_in = 1'b1;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        check(outs, 8'h00);
        check({gain, pol_b, float_b, sleep_b, presc, pin_oe}, 0);
        check(ld_en, 1);
        gap(0, 10);
        gap(1, 760);
        $display("reset test done");
        for (int i = 0; i < 8; i++)
            wr({15'h0, 1'b1, 12'h0, i[3:0]});
        check(outs, 8'hff);
        wr({15'h0, 1'b0, 12'h0, 4'h3});
        check(outs, 8'hf7);
        pin_en = 1'b0;
        repeat (6) @(negedge clk);
        check(outs, 8'h00);
        pin_en = 1'b1;
        wr(r14(0, 0, 0, 0, 4'h0, 12'h00a));
        check(outs, 8'h00);
        wr(r14(1, 0, 0, 0, 4'h0, 12'h00a));
        check(outs, 8'hf7);
        wr({15'h0, 1'b1, 12'h0, 4'hd});
        check(outs, 8'hf7);
        $display("enable test done");
        foreach (PIN_TAB[j]) begin
            wr(r14(1, 0, 0, 0, PIN_TAB[j][5:2], 12'h00a));
            check({pin_oe, pin_o & pin_oe}, PIN_TAB[j][1:0]);
        end
        ld_in = 1'b0;
        wr(r14(1, 0, 0, 0, 4'h3, 12'h00a));
        check({pin_oe, pin_o}, 2'h2);
        wr(r14(1, 0, 0, 0, 4'h4, 12'h00a));
        check({pin_oe, pin_o}, 2'h3);
        ld_in = 1'b1;
        wr(r14(1, 0, 0, 0, 4'hb, 12'h005));
        gap(2, 10);
        gap(0, 5);
        wr({2'h0, 4'h0, 18'h00003, 8'h0f});
        wr(r14(1, 0, 0, 0, 4'h9, 12'h005));
        gap(2, 6);
        gap(1, 3);
        wr(r14(1, 0, 0, 0, 4'h0, 12'hfff));
        gap(0, 4095);
        wr(r14(1, 0, 0, 0, 4'h0, 12'h000));
        quiet(0);
        for (int g = 0; g < 4; g++) begin
            wr({g[1:0], 4'h0, 18'h3ffff, 8'h0f});
            check(gain, g);
        end
        wr({2'h0, 4'h0, 18'h00000, 8'h0f});
        quiet(1);
        $display("divider test done");
        wr({16'h0, 1'b1, 11'h0, 4'hb});
        check(presc, 1);
        gap(3, 4);
        wr({16'h0, 1'b0, 11'h0, 4'hb});
        check(ld_en, 1);
        wr(r14(1, 1, 0, 0, 4'h1, 12'h00a));
        check({sleep_b, float_b, pin_oe, ld_en}, 4'hc);
        check(outs, 8'h00);
        quiet(0);
        wr(r14(1, 0, 1, 1, 4'h1, 12'h00a));
        check({sleep_b, float_b, pol_b, pin_oe}, 4'h7);
        check(outs, 8'hf7);
        $display("control test done");
        report_and_stop();
    end

    initial begin
        #600us;
        mismatches++;
        report_and_stop();
    end
endmodule : pocc_top_tb_top
`default_nettype wire
